// *** hw/adcc_top.sv ***
// module: async dma context control, ahb-lite register slave
//
// Overview of operation
// RQ1: Bits 31 to 16 of each context control register read as zero.
// RQ2: Software sets run (bit 15) to start a context, clears it to stop.
// RQ3: Hardware never changes run except through hardware or soft reset.
// RQ4: Control bits 14 and 13 read as zero.
// RQ5: Software sets wake (bit 12) to resume; each fetch clears it.
// RQ6: A fatal error sets dead (bit 11); clearing run clears it. The code sets dead only on a fatal error while active.
// RQ7: Active (bit 10) is one while descriptors are being processed.
// RQ8: Control bits 9 and 8 read as zero.
// RQ9: Speed in bits 7 to 5 codes 100, 200 and 400 Mbit/s as 0, 1, 2.
// RQ10: Speed has meaning only for receive contexts.
// RQ11: Event code in bits 4 to 0 holds the ack or an error code.
// RQ12: Setting run fetches the first block at the command pointer.
// RQ13: Pointer bits 31 to 4 give a 16-byte aligned block address.
// RQ14: Pointer bits 3 to 0 give the count of contiguous descriptors.
// RQ15: A count of zero marks the address invalid and it is not fetched.
// RQ16: Ones written at set or clear addresses set or clear bits. The clear address here acts only on run (bit 15).
// RQ17: The pointer tracks the block in progress and stays writable.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module adcc_top #(
  parameter int NCTX = adcc_pkg::NCTX
) (
  // clock, reset, enable
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // interrupt
  output logic                       irq,
  // engine side, one lane per context
  output logic [NCTX-1:0]            fetch_req,
  output logic [NCTX-1:0][31:0]      fetch_addr,
  output logic [NCTX-1:0][3:0]       fetch_cnt,
  input  wire logic [NCTX-1:0]       fetch_ack,
  input  wire logic [NCTX-1:0]       desc_done,
  input  wire logic [NCTX-1:0][31:0] next_ptr,
  input  wire logic [NCTX-1:0]       fatal_err,
  input  wire logic [NCTX-1:0]       stat_upd,
  input  wire logic [NCTX-1:0][4:0]  stat_evt,
  input  wire logic [NCTX-1:0][2:0]  stat_spd,
  output logic [NCTX-1:0]            ctx_run
);

  localparam int AW = adcc_pkg::ADDR_W;
  localparam int NI = 2 * NCTX;

  // ----------------------------------------------------------
  // ahb-lite address and data phase
  // ----------------------------------------------------------
  logic          take, dph_q, wr_q, rd_wait_q;
  logic [AW-1:0] addr_q;
  logic          wr_now;

  // hsize ignored: only whole-word transfers are used
  assign take   = hsel & htrans[1] & hready & ce;
  assign wr_now = dph_q & wr_q & ce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q     <= 1'b0;
      wr_q      <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q    <= '0;
    end else if (ce) begin
      if (hready) begin
        dph_q <= take;
        wr_q  <= take & hwrite;
      end
      if (take) begin
        addr_q <= haddr[AW-1:0];
      end
      rd_wait_q <= take & ~hwrite;
    end
  end

  // one wait state on reads so a write just before is seen
  assign hreadyout = ce & ~rd_wait_q;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  logic [NCTX-1:0] hit_set, hit_clr, hit_ptr;
  logic            hit_ist, hit_icl, hit_ien, hit_srst;
  logic            srst;

  for (genvar g = 0; g < NCTX; g++) begin : g_dec
    assign hit_set[g] = (addr_q == adcc_pkg::CTX_SET_OFF[g]);
    assign hit_clr[g] = (addr_q == adcc_pkg::CTX_CLR_OFF[g]);
    assign hit_ptr[g] = (addr_q == adcc_pkg::CTX_PTR_OFF[g]);
  end

  assign hit_ist  = (addr_q == adcc_pkg::IRQ_STAT_OFF);
  assign hit_icl  = (addr_q == adcc_pkg::IRQ_CLR_OFF);
  assign hit_ien  = (addr_q == adcc_pkg::IRQ_EN_OFF);
  assign hit_srst = (addr_q == adcc_pkg::SRST_OFF);
  // RQ3 software reset of the controller clears run
  assign srst = wr_now & hit_srst & hwdata[adcc_pkg::SRST_BIT];

  // ----------------------------------------------------------
  // contexts
  // ----------------------------------------------------------
  adcc_ctx_if cif [NCTX] ();
  logic [NCTX-1:0][31:0] ctl_v, ptr_v;
  logic [NCTX-1:0]       ev_dead, ev_stat;

  for (genvar g = 0; g < NCTX; g++) begin : g_ctx
    // RQ16 write of ones at set or clear address
    assign cif[g].set_we = wr_now & hit_set[g];
    assign cif[g].clr_we = wr_now & hit_clr[g];
    // RQ17 software may still write the pointer
    assign cif[g].ptr_we = wr_now & hit_ptr[g];
    assign cif[g].srst   = srst;
    assign cif[g].wdata  = hwdata;
    assign ctl_v[g]      = cif[g].ctl;
    assign ptr_v[g]      = cif[g].ptr;
    assign ev_dead[g]    = cif[g].ev_dead;
    assign ev_stat[g]    = cif[g].ev_stat;

    adcc_ctx #(
      .IS_RX (adcc_pkg::CTX_RX_MASK[g])
    ) u_ctx (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .ce         (ce),
      .rif        (cif[g]),
      .fetch_req  (fetch_req[g]),
      .fetch_addr (fetch_addr[g]),
      .fetch_cnt  (fetch_cnt[g]),
      .fetch_ack  (fetch_ack[g]),
      .desc_done  (desc_done[g]),
      .next_ptr   (next_ptr[g]),
      .fatal_err  (fatal_err[g]),
      .stat_upd   (stat_upd[g]),
      .stat_evt   (stat_evt[g]),
      .stat_spd   (stat_spd[g]),
      .run        (ctx_run[g])
    );
  end

  // ----------------------------------------------------------
  // interrupts: low half status updates, high half dead
  // ----------------------------------------------------------
  logic [NI-1:0] ist_q, ien_q, ev_all, icl;

  assign ev_all = {ev_dead, ev_stat};
  assign icl    = (wr_now & hit_icl) ? hwdata[NI-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= '0;
      ien_q <= '0;
    end else if (ce) begin
      // a new event beats a clear in the same cycle
      ist_q <= (ist_q & ~icl) | ev_all;
      if (wr_now && hit_ien) begin
        ien_q <= hwdata[NI-1:0];
      end
    end
  end

  assign irq = |(ist_q & ien_q);

  // ----------------------------------------------------------
  // read data
  // ----------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] hrdata_q;

  // RQ1 RQ16 both set and clear addresses read the control word
  always_comb begin
    rd_mux = adcc_pkg::ZERO_W;
    for (int i = 0; i < NCTX; i++) begin
      if (hit_set[i] || hit_clr[i]) begin
        rd_mux = ctl_v[i];
      end
      if (hit_ptr[i]) begin
        rd_mux = ptr_v[i];
      end
    end
    if (hit_ist) begin
      rd_mux[NI-1:0] = ist_q;
    end
    if (hit_ien) begin
      rd_mux[NI-1:0] = ien_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= adcc_pkg::ZERO_W;
    end else if (ce && rd_wait_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata = hrdata_q;

endmodule : adcc_top
`default_nettype wire

// *** hw/adcc_pkg.sv ***
// package: constants for the async dma context control block
package adcc_pkg;

  // ----------------------------------------------------------
  // sizes
  // ----------------------------------------------------------
  localparam int NCTX   = 4;
  localparam int ADDR_W = 12;
  localparam int DW     = 32;
  localparam int CNT_W  = 4;
  localparam int EVT_W  = 5;
  localparam int SPD_W  = 3;

  // ----------------------------------------------------------
  // register offsets, context order: req tx, resp tx, req rx, resp rx
  // ----------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTX_SET_OFF [NCTX] =
    '{12'h180, 12'h1a0, 12'h1c0, 12'h1e0};
  localparam logic [ADDR_W-1:0] CTX_CLR_OFF [NCTX] =
    '{12'h184, 12'h1a4, 12'h1c4, 12'h1e4};
  localparam logic [ADDR_W-1:0] CTX_PTR_OFF [NCTX] =
    '{12'h19c, 12'h1ac, 12'h1cc, 12'h1ec};
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 12'h1f0;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFF  = 12'h1f4;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFF   = 12'h1f8;
  localparam logic [ADDR_W-1:0] SRST_OFF     = 12'h1fc;
  localparam int                SRST_BIT     = 0;

  // receive contexts carry a meaningful speed field
  localparam logic [NCTX-1:0] CTX_RX_MASK = 4'hc;

  // ----------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------
  localparam int RUN_BIT    = 15;
  localparam int WAKE_BIT   = 12;
  localparam int DEAD_BIT   = 11;
  localparam int ACTIVE_BIT = 10;
  localparam int SPD_LSB    = 5;
  localparam int EVT_LSB    = 0;
  localparam int PTR_LSB    = 4;

  localparam logic [SPD_W-1:0] SPD_100 = 3'h0;
  localparam logic [SPD_W-1:0] SPD_200 = 3'h1;
  localparam logic [SPD_W-1:0] SPD_400 = 3'h2;

  localparam logic [DW-1:0]    ZERO_W  = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_NONE = 4'h0;
  localparam logic [EVT_W-1:0] EVT_RST = 5'h00;

  // ----------------------------------------------------------
  // context sequencer states
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_PROC, ST_WAIT, ST_HALT
  } adcc_state_t;

endpackage : adcc_pkg

// *** hw/adcc_ctx_if.sv ***
// interface: register port between the top and one context
`timescale 1ns/100ps
`default_nettype none
interface adcc_ctx_if;
  logic        set_we;
  logic        clr_we;
  logic        ptr_we;
  logic        srst;
  logic [31:0] wdata;
  logic [31:0] ctl;
  logic [31:0] ptr;
  logic        ev_dead;
  logic        ev_stat;

  modport top (
    output set_we, clr_we, ptr_we, srst, wdata,
    input  ctl, ptr, ev_dead, ev_stat
  );
  modport ctx (
    input  set_we, clr_we, ptr_we, srst, wdata,
    output ctl, ptr, ev_dead, ev_stat
  );
endinterface : adcc_ctx_if
`default_nettype wire

// *** hw/adcc_ctx.sv ***
// module: control and status of one asynchronous dma context
`timescale 1ns/100ps
`default_nettype none
module adcc_ctx #(
  parameter bit IS_RX = 1'b0
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // register side
  adcc_ctx_if.ctx          rif,
  // engine side
  output logic             fetch_req,
  output logic [31:0]      fetch_addr,
  output logic [3:0]       fetch_cnt,
  input  wire logic        fetch_ack,
  input  wire logic        desc_done,
  input  wire logic [31:0] next_ptr,
  input  wire logic        fatal_err,
  input  wire logic        stat_upd,
  input  wire logic [4:0]  stat_evt,
  input  wire logic [2:0]  stat_spd,
  output logic             run
);

  adcc_pkg::adcc_state_t st_q, st_d;
  logic        run_q, run_d, wake_q, wake_d, dead_q, dead_d;
  logic [31:0] ptr_q, ptr_d;
  logic [4:0]  evt_q;
  logic [2:0]  spd_q;
  logic        active, fetched, dead_set, run_clr;

  assign active  = (st_q == adcc_pkg::ST_FETCH) |
                   (st_q == adcc_pkg::ST_PROC);
  assign fetched = fetch_req & fetch_ack;
  assign dead_set = fatal_err & active;
  assign run_clr = rif.srst | (rif.clr_we & rif.wdata[adcc_pkg::RUN_BIT]);

  // ----------------------------------------------------------
  // control bits
  // ----------------------------------------------------------
  // RQ3 run moves only by software or reset
  // RQ16 set and clear addresses
  assign run_d = run_clr ? 1'b0 :
                 (rif.set_we & rif.wdata[adcc_pkg::RUN_BIT]) ? 1'b1 :
                 run_q;
  // RQ5 wake: software sets, fetch clears, set wins
  assign wake_d = (rif.set_we & rif.wdata[adcc_pkg::WAKE_BIT]) ? 1'b1 :
                  (fetched | rif.srst) ? 1'b0 : wake_q;
  // RQ6 dead on fatal error, gone once run is cleared
  assign dead_d = dead_set ? 1'b1 : run_clr ? 1'b0 : dead_q;
  // RQ17 pointer follows the descriptor list
  assign ptr_d = (st_q == adcc_pkg::ST_PROC && desc_done) ? next_ptr :
                 rif.ptr_we ? rif.wdata : ptr_q;

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      // RQ12 run set starts a fetch at the pointer
      // RQ15 a zero count never fetches
      adcc_pkg::ST_IDLE:
        if (run_q && !dead_q) begin
          st_d = (ptr_q[3:0] != adcc_pkg::CNT_NONE) ?
                 adcc_pkg::ST_FETCH : adcc_pkg::ST_WAIT;
        end
      adcc_pkg::ST_FETCH:
        if (fetch_ack) begin
          st_d = adcc_pkg::ST_PROC;
        end
      adcc_pkg::ST_PROC:
        if (desc_done) begin
          st_d = (next_ptr[3:0] != adcc_pkg::CNT_NONE) ?
                 adcc_pkg::ST_FETCH : adcc_pkg::ST_WAIT;
        end
      // RQ5 wake resumes from the held pointer
      adcc_pkg::ST_WAIT:
        if (wake_q && ptr_q[3:0] != adcc_pkg::CNT_NONE) begin
          st_d = adcc_pkg::ST_FETCH;
        end
      adcc_pkg::ST_HALT:
        st_d = adcc_pkg::ST_HALT;
      default:
        st_d = adcc_pkg::ST_IDLE;
    endcase
    if (dead_set) begin
      st_d = adcc_pkg::ST_HALT;
    end
    // halted context waits for run to drop
    if (!run_q) begin
      st_d = adcc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= adcc_pkg::ST_IDLE;
      run_q  <= 1'b0;
      wake_q <= 1'b0;
      dead_q <= 1'b0;
      ptr_q  <= adcc_pkg::ZERO_W;
    end else if (ce) begin
      st_q   <= st_d;
      run_q  <= run_d;
      wake_q <= wake_d;
      dead_q <= dead_d;
      ptr_q  <= ptr_d;
    end
  end

  // RQ11 acknowledge or error code per packet
  // RQ10 transmit contexts leave speed at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= adcc_pkg::EVT_RST;
      spd_q <= adcc_pkg::SPD_100;
    end else if (ce && stat_upd) begin
      evt_q <= stat_evt;
      spd_q <= IS_RX ? stat_spd : adcc_pkg::SPD_100;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  // RQ1 RQ4 RQ8 unused positions read zero
  always_comb begin
    rif.ctl = adcc_pkg::ZERO_W;
    rif.ctl[adcc_pkg::RUN_BIT]    = run_q;
    rif.ctl[adcc_pkg::WAKE_BIT]   = wake_q;
    rif.ctl[adcc_pkg::DEAD_BIT]   = dead_q;
    // RQ7 active while processing
    rif.ctl[adcc_pkg::ACTIVE_BIT] = active;
    // RQ9 speed code field
    rif.ctl[adcc_pkg::SPD_LSB +: 3] = spd_q;
    rif.ctl[adcc_pkg::EVT_LSB +: 5] = evt_q;
  end

  assign rif.ptr     = ptr_q;
  assign rif.ev_dead = dead_set;
  assign rif.ev_stat = stat_upd;
  assign fetch_req   = (st_q == adcc_pkg::ST_FETCH);
  // RQ13 16-byte aligned block address
  assign fetch_addr  = {ptr_q[31:adcc_pkg::PTR_LSB], 4'h0};
  // RQ14 count of contiguous descriptors
  assign fetch_cnt   = ptr_q[3:0];
  assign run         = run_q;

endmodule : adcc_ctx
`default_nettype wire

// *** verif/adcc_asserts.sv ***
// checker: bus timing and context control properties at the top ports
`timescale 1ns/100ps
`default_nettype none
module adcc_asserts #(
  parameter int NCTX = 4
) (
  // clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  ce,
  // ahb-lite
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic [31:0]           hrdata,
  // context lanes
  input wire logic [NCTX-1:0]       fetch_req,
  input wire logic [NCTX-1:0][31:0] fetch_addr,
  input wire logic [NCTX-1:0][3:0]  fetch_cnt,
  input wire logic [NCTX-1:0]       ctx_run
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // decode helpers; control reads are checked on every context, run and fetch on lane 2 only
  // ----------------------------------------
  wire logic [11:0] a12 = haddr[11:0];
  wire logic        tk  = hsel & htrans[1] & hready & ce;
  wire logic        ctl = a12[11:7] == 5'h03 && a12[4:3] == 2'h0
                          && a12[1:0] == 2'h0;
  wire logic        go  = tk && hwrite && a12 == 12'h1c0;
  wire logic        stp = tk && hwrite && (a12 == 12'h1c4
                          || a12 == 12'h1fc);
  sequence rd_take; tk && !hwrite; endsequence
  sequence rd_ctl; tk && !hwrite && ctl; endsequence
  sequence rd_data; !hreadyout ##1 hreadyout; endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  rd_wait_a: assert property (rd_take |=> rd_data)
    else $error("read answer timing wrong");
  wr_nowait_a: assert property (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  hi_bits_zero_a: assert property (
    rd_ctl ##1 rd_data |-> hrdata[31:16] == 16'h0000)
    else $error("upper control bits not zero");
  mid_bits_zero_a: assert property (
    rd_ctl ##1 rd_data |-> hrdata[14:13] == 2'h0 && hrdata[9:8] == 2'h0)
    else $error("reserved control bits not zero");
  tx_spd_zero_a: assert property (
    rd_ctl and !a12[6] ##1 rd_data |-> hrdata[7:5] == 3'h0)
    else $error("transmit speed not zero");
  run_rise_a: assert property ($rose(ctx_run[2]) |-> $past(go, 2))
    else $error("run rose without a set write");
  run_fall_a: assert property ($fell(ctx_run[2]) |-> $past(stp, 2))
    else $error("run fell without a clear write");
  fetch_on_run_a: assert property (
    $rose(ctx_run[2]) && fetch_cnt[2] != 4'h0 |=> fetch_req[2])
    else $error("no fetch after run");
  fetch_cnt_a: assert property (fetch_req[2] |-> fetch_cnt[2] != 4'h0)
    else $error("fetch with zero count");
  fetch_align_a: assert property (
    fetch_req[2] |-> fetch_addr[2][3:0] == 4'h0)
    else $error("fetch address not aligned");
endmodule : adcc_asserts
bind adcc_top adcc_asserts #(.NCTX(NCTX)) chk_u (
  .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .fetch_req, .fetch_addr, .fetch_cnt, .ctx_run
);
`default_nettype wire

// *** verif/adcc_eng_model.sv ***
// partner model: engine that answers fetches and finishes blocks
`timescale 1ns/100ps
`default_nettype none
module adcc_eng_model (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // engine lanes
  input  wire logic [3:0]       fetch_req,
  output logic [3:0]            fetch_ack,
  output logic [3:0]            desc_done,
  output logic [3:0][31:0]      next_ptr,
  // knobs: answer delay, pointer handed back
  input  wire logic [7:0]       dly,
  input  wire logic [3:0][31:0] nxt
);
  logic [1:0] ph [4];
  logic [7:0] wt [4];
  always @(posedge hclk or negedge hresetn) begin
    for (int c = 0; c < 4; c++) begin
      fetch_ack[c] <= 1'b0;
      desc_done[c] <= 1'b0;
      // idle lines toggle so a stale pointer is never read
      next_ptr[c]  <= ~next_ptr[c];
      if (!hresetn) begin
        ph[c]       <= 2'h0;
        wt[c]       <= 8'h00;
        next_ptr[c] <= 32'h0000_0000;
      end else if (ph[c] == 2'h0) begin
        ph[c] <= {1'b0, fetch_req[c]};
        wt[c] <= dly;
      end else if (wt[c] != 8'h00) begin
        wt[c] <= wt[c] - 8'h01;
      end else if (ph[c] == 2'h1) begin
        // acknowledge only a request that still stands
        fetch_ack[c] <= fetch_req[c];
        ph[c]        <= fetch_req[c] ? 2'h2 : 2'h0;
        wt[c]        <= dly;
      end else begin
        desc_done[c] <= 1'b1;
        next_ptr[c]  <= nxt[c];
        ph[c]        <= 2'h0;
      end
    end
  end
endmodule : adcc_eng_model
`default_nettype wire

// *** verif/adcc_tb_top.sv ***
// testbench: registers, fetch flow, events and resets of the block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (e)); \
  end \
end
module adcc_tb_top;
  logic             hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, r;
  logic [3:0]       fetch_req, fetch_ack, desc_done, fatal_err;
  logic [3:0]       stat_upd, ctx_run;
  logic [3:0][31:0] fetch_addr, next_ptr, nxt;
  logic [3:0][3:0]  fetch_cnt;
  logic [3:0][4:0]  stat_evt;
  logic [3:0][2:0]  stat_spd;
  logic [7:0]       dly;
  int               fail_count, check_count;
  localparam logic [11:0] set2 = adcc_pkg::CTX_SET_OFF[2];
  localparam logic [11:0] ptr2 = adcc_pkg::CTX_PTR_OFF[2];
  adcc_top dut_u (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .irq, .fetch_req, .fetch_addr, .fetch_cnt, .fetch_ack, .desc_done,
    .next_ptr, .fatal_err, .stat_upd, .stat_evt, .stat_spd, .ctx_run
  );
  adcc_eng_model eng_u (
    .hclk, .hresetn, .fetch_req, .fetch_ack, .desc_done, .next_ptr,
    .dly, .nxt
  );
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ----------------------------------------
  // bus and helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0_0000, a};
    // no local limit: a stuck slave is caught by the watchdog
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wait_req(input int c);
    int n;
    n = 0;
    while (fetch_req[c] !== 1'b1 && n++ < 64) @(posedge hclk);
    `CHK(fetch_req[c], 1'b1)
  endtask : wait_req
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int c = 0; c < 4; c++) begin
      bus(1'b0, adcc_pkg::CTX_SET_OFF[c], 32'h0000_0000);
      `CHK(r & 32'hffff_ef00, 32'h0000_0000)
    end
    bus(1'b0, 12'h100, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    `CHK({irq, ctx_run}, 5'h00)
  endtask : t_reset
  task automatic t_setclr();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, adcc_pkg::CTX_PTR_OFF[c], 32'h0000_1230);
      bus(1'b1, adcc_pkg::CTX_SET_OFF[c], 32'hffff_ffff);
      repeat (4) @(posedge hclk);
      bus(1'b0, adcc_pkg::CTX_CLR_OFF[c], 32'h0000_0000);
      `CHK(r & 32'hffff_ef00, 32'h0000_8000)
      `CHK(fetch_req[c], 1'b0)
      bus(1'b1, adcc_pkg::CTX_CLR_OFF[c], 32'h0000_0000);
      @(posedge hclk);
      `CHK(ctx_run[c], 1'b1)
      bus(1'b1, adcc_pkg::CTX_CLR_OFF[c], 32'h0000_8000);
      @(posedge hclk);
      `CHK(ctx_run[c], 1'b0)
    end
  endtask : t_setclr
  task automatic t_fetch();
    dly    <= 8'h00;
    nxt[2] <= 32'h4560_0000;
    bus(1'b1, ptr2, 32'h1230_0003);
    bus(1'b1, set2, 32'h0000_8000);
    wait_req(2);
    `CHK(fetch_addr[2], 32'h1230_0000)
    `CHK(fetch_cnt[2], 4'h3)
    repeat (6) @(posedge hclk);
    bus(1'b0, ptr2, 32'h0000_0000);
    `CHK(r, 32'h4560_0000)
    // wake left set earlier must be gone after the fetch
    bus(1'b0, set2, 32'h0000_0000);
    `CHK(r[12:10], 3'b000)
    // slow engine now, so the fetch is still open when looked at
    dly <= 8'h0c;
    bus(1'b1, ptr2, 32'h7890_0001);
    bus(1'b1, set2, 32'h0000_1000);
    wait_req(2);
    `CHK(fetch_addr[2], 32'h7890_0000)
    bus(1'b0, set2, 32'h0000_0000);
    `CHK(r[12:10], 3'b101)
    @(posedge hclk) fatal_err[2] <= 1'b1;
    @(posedge hclk) fatal_err[2] <= 1'b0;
    bus(1'b0, set2, 32'h0000_0000);
    `CHK(r[15:10], 6'h26)
    bus(1'b1, adcc_pkg::CTX_CLR_OFF[2], 32'h0000_8000);
    bus(1'b0, set2, 32'h0000_0000);
    `CHK(r[11], 1'b0)
  endtask : t_fetch
  task automatic t_stat();
    logic [2:0] sp [3];
    sp = '{adcc_pkg::SPD_100, adcc_pkg::SPD_200, adcc_pkg::SPD_400};
    stat_evt <= {4{5'h11}};
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk) stat_spd <= {4{sp[i]}};
      stat_upd <= 4'h5;
      @(posedge hclk) stat_upd <= 4'h0;
      bus(1'b0, set2, 32'h0000_0000);
      `CHK(r[7:0], {sp[i], 5'h11})
    end
    bus(1'b0, adcc_pkg::CTX_SET_OFF[0], 32'h0000_0000);
    `CHK(r[7:0], 8'h11)
    bus(1'b1, adcc_pkg::IRQ_EN_OFF, 32'h0000_0004);
    @(posedge hclk);
    `CHK(irq, 1'b1)
    bus(1'b0, adcc_pkg::IRQ_STAT_OFF, 32'h0000_0000);
    `CHK(r, 32'h0000_0045)
    bus(1'b1, adcc_pkg::IRQ_EN_OFF, 32'h0000_0000);
    @(posedge hclk);
    `CHK(irq, 1'b0)
    bus(1'b1, adcc_pkg::IRQ_EN_OFF, 32'h0000_0040);
    bus(1'b1, adcc_pkg::IRQ_CLR_OFF, 32'h0000_00ff);
    bus(1'b0, adcc_pkg::IRQ_STAT_OFF, 32'h0000_0000);
    `CHK({irq, r}, 33'h0_0000_0000)
  endtask : t_stat
  task automatic t_resets();
    // frozen clock enable must drop a status update
    ce <= 1'b0;
    @(posedge hclk) stat_upd <= 4'hf;
    stat_evt <= {4{5'h1f}};
    @(posedge hclk) stat_upd <= 4'h0;
    ce <= 1'b1;
    bus(1'b0, set2, 32'h0000_0000);
    `CHK(r[4:0], 5'h11)
    bus(1'b1, adcc_pkg::CTX_PTR_OFF[1], 32'h0000_2000);
    bus(1'b1, adcc_pkg::CTX_SET_OFF[1], 32'h0000_8000);
    bus(1'b1, adcc_pkg::SRST_OFF, 32'h0000_0001);
    @(posedge hclk);
    `CHK(ctx_run, 4'h0)
    bus(1'b0, adcc_pkg::CTX_PTR_OFF[1], 32'h0000_0000);
    `CHK(r, 32'h0000_2000)
    bus(1'b1, adcc_pkg::CTX_SET_OFF[1], 32'h0000_8000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(ctx_run, 4'h0)
  endtask : t_resets
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    end_of_test();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {fatal_err, stat_upd, stat_evt, stat_spd, nxt, dly} = '0;
    hsize = 3'h2;
    ce = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_setclr();
    t_fetch();
    t_stat();
    t_resets();
    end_of_test();
  end
endmodule : adcc_tb_top
`default_nettype wire
